// *** core/tx_line_defines.vh ***
// Purpose: Constants for the transmit line driver and drive monitor.
// Assumes: Avalon-MM slave with 32-bit data and byte addresses.
// Notes:   Included by bare name from the design file.
`ifndef TX_LINE_DEFINES_VH
`define TX_LINE_DEFINES_VH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define REG_CTRL_OFS 4'h0
`define REG_STATUS_OFS 4'h4

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CTRL_HOST_BIT 0
`define CTRL_TXON_LSB 8
`define CTRL_IMON_LSB 16
`define STAT_FAULT_LSB 0
`define STAT_FULL_LSB 8
`define STAT_TXON_LSB 16
`define STAT_HOST_BIT 24

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_HOST 1'h0
`define RST_TXON 8'h00
`define RST_IMON 8'h00

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define MON_WINDOW_BITS 8'h80

`endif

// *** core/tx_line_driver_monitor.v ***
// Purpose: Three channel transmit line output control with drive
//          monitoring, behind an Avalon-MM register slave.
// Assumes: All pins but the Avalon-MM bus and rst_b are asynchronous to mclk and are synchronised;
//          each transmit clock is much slower than mclk.
// Notes:   Line outputs are logic-level images of the bipolar drive.
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`include "tx_line_defines.vh"

// ---------------------------------------------------------------
// Small FIFO with valid/ready on both sides
// ---------------------------------------------------------------
module tx_word_fifo #(
   parameter WIDTH = 2,
   parameter DEPTH = 4,
   parameter AW = 2
)(
   input wire mclk,                 // System clock
   input wire rst_b,                // Synchronous reset, active low
   input wire in_valid,             // Word offered
   output wire in_ready,            // Room for a word
   input wire [WIDTH-1:0] in_data,  // Word to store
   output wire out_valid,           // Word available
   input wire out_ready,            // Drain takes the word
   output wire [WIDTH-1:0] out_data // Oldest word
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] count_r;
   wire push;
   wire pop;
   localparam [AW:0] FULL_CNT = DEPTH[AW:0];
   localparam [AW-1:0] LAST = FULL_CNT[AW-1:0] - 1'b1;

   assign in_ready = (count_r != FULL_CNT);
   assign out_valid = (count_r != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge mclk)
   begin
      if (push)
      begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always @(posedge mclk)
   begin
      if (!rst_b)
      begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= (wr_ptr_r == LAST) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_r <= (rd_ptr_r == LAST) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
         end
         if (push && !pop)
         begin
            count_r <= count_r + 1'b1;
         end
         else if (pop && !push)
         begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule // tx_word_fifo

// Operation
// - Fault high after 128 silent bit periods
// - Fault low if pulse within 128 periods
// - Monitor source external pins or internal tap
// - Edge select high: sample on rising edge
// - Edge select low: sample on falling edge
// - Host mode: edge select pin not used
// - Negative pulse: positive output below negative
// - Transmitter off: both outputs high impedance
// - Internal monitoring only offered in host mode
// - Internal monitoring ignores external monitor inputs
module tx_line_driver_monitor #(
   parameter CH = 3,
   parameter FIFO_DEPTH = 4,
   parameter FIFO_AW = 2
)(
   input wire mclk,                    // System clock, 250 MHz
   input wire rst_b,                   // Synchronous reset, active low
   input wire [3:0] avs_address,       // Byte address
   input wire avs_read,                // Read request
   input wire avs_write,               // Write request
   input wire [31:0] avs_writedata,    // Write data
   output reg [31:0] avs_readdata,     // Read data
   output wire avs_waitrequest,        // Stall while high
   input wire [CH-1:0] tx_data_clock,  // Per channel bit clock
   input wire [CH-1:0] tx_pos_rail_in, // Positive rail data
   input wire [CH-1:0] tx_neg_rail_in, // Negative rail data
   input wire tx_edge_select,          // Sampling edge; serial clock in host
   input wire [CH-1:0] tx_driver_on,   // Transmitter on pins
   input wire [CH-1:0] monitor_pos_in, // External monitor positive
   input wire [CH-1:0] monitor_neg_in, // External monitor negative
   output reg [CH-1:0] line_out_pos,   // Line output positive
   output reg [CH-1:0] line_out_neg,   // Line output negative
   output reg [CH-1:0] line_out_oe,    // Line output enable
   output reg [CH-1:0] drive_fault_flag // No pulse for 128 bits
);
   localparam SW = 6 * CH + 1;
   localparam [7:0] WIN = `MON_WINDOW_BITS;
   localparam [7:0] RST_TXON_ALL = `RST_TXON;
   localparam [7:0] RST_IMON_ALL = `RST_IMON;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   reg [SW-1:0] pin_meta_r;
   reg [SW-1:0] pin_sync_r;
   reg [CH-1:0] clk_prev_r;
   wire [SW-1:0] pin_raw;
   wire [CH-1:0] clk_s;
   wire [CH-1:0] pos_s;
   wire [CH-1:0] neg_s;
   wire [CH-1:0] on_s;
   wire [CH-1:0] mpos_s;
   wire [CH-1:0] mneg_s;
   wire edge_s;

   assign pin_raw = {tx_edge_select, monitor_neg_in, monitor_pos_in,
                     tx_driver_on, tx_neg_rail_in, tx_pos_rail_in,
                     tx_data_clock};
   assign clk_s = pin_sync_r[CH-1:0];
   assign pos_s = pin_sync_r[2*CH-1:CH];
   assign neg_s = pin_sync_r[3*CH-1:2*CH];
   assign on_s = pin_sync_r[4*CH-1:3*CH];
   assign mpos_s = pin_sync_r[5*CH-1:4*CH];
   assign mneg_s = pin_sync_r[6*CH-1:5*CH];
   assign edge_s = pin_sync_r[SW-1];

   always @(posedge mclk)
   begin
      if (!rst_b)
      begin
         pin_meta_r <= {SW{1'b0}};
         pin_sync_r <= {SW{1'b0}};
         clk_prev_r <= {CH{1'b0}};
      end
      else
      begin
         pin_meta_r <= pin_raw;
         pin_sync_r <= pin_meta_r;
         clk_prev_r <= clk_s;
      end
   end

   // ------------------------------------------------------------
   // Avalon-MM register slave
   // ------------------------------------------------------------
   reg host_mode_r;
   reg [CH-1:0] sw_tx_on_r;
   reg [CH-1:0] int_mon_r;
   reg ack_r;
   reg [31:0] rd_nxt;
   wire req;
   wire [CH-1:0] fifo_full;
   wire [CH-1:0] tx_on_eff;

   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_r;
   // Pins steer the transmitters in hardware mode, bits in host mode
   assign tx_on_eff = host_mode_r ? sw_tx_on_r : on_s;

   always @*
   begin
      rd_nxt = 32'h0000_0000;
      case (avs_address)
         `REG_CTRL_OFS:
         begin
            rd_nxt[`CTRL_HOST_BIT] = host_mode_r;
            rd_nxt[`CTRL_TXON_LSB +: CH] = sw_tx_on_r;
            rd_nxt[`CTRL_IMON_LSB +: CH] = int_mon_r;
         end
         `REG_STATUS_OFS:
         begin
            rd_nxt[`STAT_FAULT_LSB +: CH] = drive_fault_flag;
            rd_nxt[`STAT_FULL_LSB +: CH] = fifo_full;
            rd_nxt[`STAT_TXON_LSB +: CH] = tx_on_eff;
            rd_nxt[`STAT_HOST_BIT] = host_mode_r;
         end
         default:
         begin
            rd_nxt = 32'h0000_0000;
         end
      endcase
   end

   always @(posedge mclk)
   begin
      if (!rst_b)
      begin
         ack_r <= 1'b0;
         avs_readdata <= 32'h0000_0000;
         host_mode_r <= `RST_HOST;
         sw_tx_on_r <= RST_TXON_ALL[CH-1:0];
         int_mon_r <= RST_IMON_ALL[CH-1:0];
      end
      else
      begin
         ack_r <= req & ~ack_r;
         if (avs_read && !ack_r)
         begin
            avs_readdata <= rd_nxt;
         end
         if (avs_write && ack_r && avs_address == `REG_CTRL_OFS)
         begin
            host_mode_r <= avs_writedata[`CTRL_HOST_BIT];
            sw_tx_on_r <= avs_writedata[`CTRL_TXON_LSB +: CH];
            int_mon_r <= avs_writedata[`CTRL_IMON_LSB +: CH];
         end
      end
   end

   // ------------------------------------------------------------
   // Sampling edge choice
   // ------------------------------------------------------------
   wire rise_sel;
   wire [CH-1:0] bit_rise;
   wire [CH-1:0] bit_fall;
   wire [CH-1:0] sample_edge;

   // Host mode: the shared pin is the serial clock, keep rising edge
   assign rise_sel = host_mode_r ? 1'b1 : edge_s;
   assign bit_rise = clk_s & ~clk_prev_r;
   assign bit_fall = ~clk_s & clk_prev_r;
   assign sample_edge = rise_sel ? bit_rise : bit_fall;

   // ------------------------------------------------------------
   // Per channel data path and drive monitor
   // ------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < CH; i = i + 1)
      begin : g_ch
         wire in_ready;
         wire out_valid;
         wire [1:0] out_data;
         wire drain;
         wire use_int;
         wire tap;
         wire act;
         reg seen_r;
         reg [7:0] quiet_r;
         reg [7:0] quiet_nxt;

         assign fifo_full[i] = ~in_ready;
         // A stopped driver stalls the drain, so the FIFO fills and
         // further samples are refused until the driver returns
         assign drain = sample_edge[i] & tx_on_eff[i];

         tx_word_fifo #(
            .WIDTH(2),
            .DEPTH(FIFO_DEPTH),
            .AW(FIFO_AW)
         ) u_fifo (
            .mclk(mclk),
            .rst_b(rst_b),
            .in_valid(sample_edge[i]),
            .in_ready(in_ready),
            .in_data({pos_s[i], neg_s[i]}),
            .out_valid(out_valid),
            .out_ready(drain),
            .out_data(out_data)
         );

         always @(posedge mclk)
         begin
            if (!rst_b)
            begin
               line_out_pos[i] <= 1'b0;
               line_out_neg[i] <= 1'b0;
               line_out_oe[i] <= 1'b0;
            end
            else
            begin
               line_out_oe[i] <= tx_on_eff[i];
               if (!tx_on_eff[i])
               begin
                  line_out_pos[i] <= 1'b0;
                  line_out_neg[i] <= 1'b0;
               end
               else if (drain)
               begin
                  // Both rails high is sent as a zero
                  line_out_pos[i] <= out_valid & out_data[1] &
                                     ~out_data[0];
                  line_out_neg[i] <= out_valid & out_data[0] &
                                     ~out_data[1];
               end
            end
         end

         // Internal tap exists only in host mode
         assign use_int = host_mode_r & int_mon_r[i];
         assign tap = use_int ?
                      (line_out_oe[i] & (line_out_pos[i] ^ line_out_neg[i]))
                      : (mpos_s[i] ^ mneg_s[i]);
         assign act = seen_r | tap;

         always @*
         begin
            quiet_nxt = quiet_r;
            if (bit_rise[i])
            begin
               if (act)
               begin
                  quiet_nxt = 8'h00;
               end
               else if (quiet_r != WIN)
               begin
                  quiet_nxt = quiet_r + 8'h01;
               end
            end
         end

         always @(posedge mclk)
         begin
            if (!rst_b)
            begin
               seen_r <= 1'b0;
               quiet_r <= 8'h00;
               drive_fault_flag[i] <= 1'b0;
            end
            else
            begin
               // A pulse in the edge cycle counts in the closing period
               seen_r <= bit_rise[i] ? 1'b0 : act;
               quiet_r <= quiet_nxt;
               drive_fault_flag[i] <= (quiet_nxt == WIN);
            end
         end
      end
   endgenerate
endmodule // tx_line_driver_monitor

// *** tb/tx_line_checker_monitor.sv ***
// Purpose: Port checker for the line driver and drive monitor.
// Assumes: Channel 0 stands for all; bit clock slow against mclk.
// Notes:   Quiet counters follow the tap and the monitor pins apart.
module tx_line_checker #(
   parameter CH = 3
)(
   input wire logic mclk, // System clock
   input wire logic rst_b, // Reset, active low
   input wire logic [3:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic avs_waitrequest, // Stall
   input wire logic [CH-1:0] tx_data_clock, // Bit clocks
   input wire logic [CH-1:0] tx_driver_on, // Transmitter pins
   input wire logic [CH-1:0] monitor_pos_in, // Monitor positive
   input wire logic [CH-1:0] monitor_neg_in, // Monitor negative
   input wire logic [CH-1:0] line_out_pos, // Line positive
   input wire logic [CH-1:0] line_out_neg, // Line negative
   input wire logic [CH-1:0] line_out_oe, // Line enable
   input wire logic [CH-1:0] drive_fault_flag // Fault flags
);
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_d_r, host_r;
   logic [7:0] cnt_l_r, cnt_m_r;
   wire rise = tx_data_clock[0] & ~clk_d_r;
   wire lpul = line_out_oe[0] & (line_out_pos[0] ^ line_out_neg[0]);
   wire mpul = monitor_pos_in[0] ^ monitor_neg_in[0];
   // Bit clock rises since the last pulse, per source
   always_ff @(posedge mclk)
   begin
      clk_d_r <= tx_data_clock[0];
      if (!rst_b)
         host_r <= 1'h0;
      else if (avs_write && !avs_waitrequest && avs_address == 4'h0)
         host_r <= avs_writedata[0];
      if (!rst_b || lpul)
         cnt_l_r <= 8'h00;
      else if (rise && cnt_l_r != 8'hFF)
         cnt_l_r <= cnt_l_r + 8'h01;
      if (!rst_b || mpul)
         cnt_m_r <= 8'h00;
      else if (rise && cnt_m_r != 8'hFF)
         cnt_m_r <= cnt_m_r + 8'h01;
   end
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_pin_off;
      (!host_r && !tx_driver_on[0]) [*6];
   endsequence
   a_wait_one: assert property (s_req |=> !avs_waitrequest)
      else $error("waitrequest high for more than one cycle");
   a_wait_idle: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
      else $error("waitrequest without a request");
   a_fault_sets: assert property (
      cnt_l_r > 8'h84 && cnt_m_r > 8'h84 |-> drive_fault_flag[0])
      else $error("no fault after a long quiet line");
   a_fault_cause: assert property ($rose(drive_fault_flag[0]) |->
      cnt_l_r >= 8'h78 || cnt_m_r >= 8'h78)
      else $error("fault raised with recent pulses");
   a_hw_external: assert property ($rose(drive_fault_flag[0])
      && !host_r |-> cnt_m_r >= 8'h78)
      else $error("fault in hardware mode not from monitor pins");
   a_fault_clears: assert property ($fell(drive_fault_flag[0]) |->
      cnt_l_r <= 8'h03 || cnt_m_r <= 8'h03)
      else $error("fault cleared without a pulse");
   a_no_both: assert property (~|(line_out_pos & line_out_neg))
      else $error("both line outputs high");
   a_hiz_quiet: assert property (
      ~|(~line_out_oe & (line_out_pos | line_out_neg)))
      else $error("data on a released line");
   a_pin_off: assert property (s_pin_off |-> !line_out_oe[0])
      else $error("line driven with transmitter pin off");
endmodule // tx_line_checker

bind tx_line_driver_monitor tx_line_checker #(.CH(CH)) chk_u (.mclk, .rst_b,
   .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_waitrequest,
   .tx_data_clock, .tx_driver_on, .monitor_pos_in, .monitor_neg_in,
   .line_out_pos, .line_out_neg, .line_out_oe, .drive_fault_flag);

// *** tb/line_far_end.sv ***
// Purpose: Far end of the line with the external monitor taps.
// Assumes: Monitor pins are wired to the line outputs.
// Notes:   cut opens the taps; inject fakes activity on them.
module line_far_end (
   input wire logic mclk, // System clock
   input wire logic cut, // Taps open
   input wire logic inject, // Fake pulse train on the taps
   input wire logic [2:0] line_out_pos, // Line positive
   input wire logic [2:0] line_out_neg, // Line negative
   input wire logic [2:0] line_out_oe, // Line enable
   output logic [2:0] mon_pos, // To monitor positive
   output logic [2:0] mon_neg // To monitor negative
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tog_r = 1'h0;
   always @(posedge mclk)
      tog_r <= ~tog_r;
   // A released line sits equal at both taps across the transformer
   always_comb
   begin
      mon_pos = inject ? {3{tog_r}} : cut ? 3'h0 : line_out_oe & line_out_pos;
      mon_neg = inject || cut ? 3'h0 : line_out_oe & line_out_neg;
   end
endmodule // line_far_end

// *** tb/tx_line_driver_monitor_tb_top.sv ***
// Purpose: Self-checking bench for the line driver and monitor.
// Assumes: All channels share one bit clock and one rail pattern.
// Notes:   Rails follow the bit clock level one cycle late.
module tx_line_driver_monitor_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_b, avs_read, avs_write, avs_waitrequest, tclk, es;
   logic cut, inj;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [2:0] txon, rp, rn, mp, mn, lp, ln, oe, flt;
   logic [1:0] hi, lo;
   int err_total, samples_checked;
   tx_line_driver_monitor uut (.mclk(mclk), .rst_b(rst_b),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .tx_data_clock({3{tclk}}), .tx_pos_rail_in(rp), .tx_neg_rail_in(rn),
      .tx_edge_select(es), .tx_driver_on(txon), .monitor_pos_in(mp),
      .monitor_neg_in(mn), .line_out_pos(lp), .line_out_neg(ln),
      .line_out_oe(oe), .drive_fault_flag(flt));
   line_far_end far (.mclk(mclk), .cut(cut), .inject(inj),
      .line_out_pos(lp), .line_out_neg(ln), .line_out_oe(oe),
      .mon_pos(mp), .mon_neg(mn));
   initial
   begin
      mclk = 1'h0;
      forever #2 mclk = ~mclk;
   end
   initial
   begin
      tclk = 1'h0;
      #5;
      forever #16 tclk = ~tclk;
   end
   always @(posedge mclk)
   begin
      rp <= {3{tclk ? hi[1] : lo[1]}};
      rn <= {3{tclk ? hi[0] : lo[0]}};
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task results;
      if (err_total == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      for (n = 0; n < 50; n++)
      begin
         @(posedge mclk);
         if (!avs_waitrequest)
            break;
      end
      q = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      if (n == 50)
      begin
         err_total++;
         results;
      end
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      bus(1'h0, a, 32'h0);
      chk(q & m, e);
   endtask
   task bits(input int n);
      repeat (n) @(posedge tclk);
      @(posedge mclk);
   endtask
   initial
   begin
      rst_b = 1'h0;
      avs_read = 1'h0;
      avs_write = 1'h0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      {txon, cut, inj} = 5'h00;
      es = 1'h1;
      hi = 2'h1;
      lo = 2'h2;
      err_total = 0;
      samples_checked = 0;
      repeat (8) @(posedge mclk);
      rst_b <= 1'h1;
      rd(4'h0, 32'h0, 32'hFFFF_FFFF);
      bus(1'h1, 4'h8, 32'hFFFF_FFFF);
      rd(4'h8, 32'h0, 32'hFFFF_FFFF);
      rd(4'h0, 32'h0, 32'hFFFF_FFFF);
      bits(6);
      chk({oe, lp, ln}, 9'h000);
      rd(4'h4, 32'h0000_0700, 32'hFFFF_FFFF);
      txon <= 3'h7;
      bits(8);
      chk({oe, lp, ln}, 9'h1F8);
      es <= 1'h0;
      bits(8);
      chk({oe, lp, ln}, 9'h1C7);
      hi <= 2'h0;
      lo <= 2'h0;
      bits(120);
      chk(flt, 3'h0);
      bits(16);
      chk(flt, 3'h7);
      hi <= 2'h2;
      lo <= 2'h2;
      bits(6);
      chk(flt, 3'h0);
      cut <= 1'h1;
      bits(136);
      chk(flt, 3'h7);
      bus(1'h1, 4'h0, 32'h0007_0000);
      bits(136);
      chk(flt, 3'h7);
      bus(1'h1, 4'h0, 32'h0007_0701);
      hi <= 2'h1;
      bits(136);
      chk(flt, 3'h0);
      chk({lp, ln}, 6'h38);
      rd(4'h4, 32'h0107_0000, 32'hFFFF_F8FF);
      hi <= 2'h0;
      lo <= 2'h0;
      inj <= 1'h1;
      bits(136);
      chk(flt, 3'h7);
      bus(1'h1, 4'h0, 32'h0000_0001);
      bits(1);
      chk(oe, 3'h0);
      rd(4'h0, 32'h0000_0001, 32'hFFFF_FFFF);
      results;
   end
endmodule // tx_line_driver_monitor_tb_top
